/* hdl/smp_pkg.sv */
// How it works
// - Stop with stop_allow clear enters no level and raises an illegal-opcode reset.
// - Level: debug, both low-volt bits, pdc 0 give light; partial_power_down_ctl picks middle or deep.
// - Light stop keeps registers, RAM and every pin state unchanged.
// - Light stop ends on reset pin or timer, low-volt, converter, irq or keypad.
// - Reset-pin exit gives full reset and reset vector; interrupts give their vector.
// - Both low-volt bits set at entry keep the regulator fully active.
// - Converter runs in light stop only with async clock and detector kept on.
// - Debug allowed at entry keeps debug clock running and regulator in full regulation.
// - While stopped, memory-status debug commands return a stop/wait error, no access.
// - With debug allowed a background command wakes into background; then all accepted.
// - Middle stop powers down all but RAM and latches every pin control.
// - Middle and deep stop use the wake pin as active-low input, pull-up off.
// - The periodic wake timer wakes the device from middle and deep stop.
// - Middle or deep wake restarts as power-on: controls reset, low-trip hold, reset vector.
// - Middle wake sets the partial flag; flag and pin latches hold until ack written.
// - Once latches open pins follow current port registers or enabled peripheral.
// - Deep stop powers nearly everything down and drives pins high impedance.
// - Deep wake sets the power-down flag until ack written.
// - Every stop level stops peripheral clocks, debug clock notwithstanding.
// - Internal clock source runs in light stop only with both its enables set.
// - Oscillator runs in light stop with both enables; high range also needs detector.
//
// Purpose: constants, register map and carrier types of the stop-mode sequencer
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes:   control bits all sit in one word, flags and ack in a second

package smp_pkg;

	// Register byte offsets
	localparam logic [3:0] SMP_OFS_CTRL   = 4'h0;
	localparam logic [3:0] SMP_OFS_STATUS = 4'h4;

	// Control word field positions
	localparam int SMP_B_STOP_ALLOW   = 0;
	localparam int SMP_B_LV_ON        = 1;
	localparam int SMP_B_LV_IN_STOP   = 2;
	localparam int SMP_B_PDC          = 3;
	localparam int SMP_B_PARTIAL_POWER_DOWN_CTL         = 4;
	localparam int SMP_B_DEBUG_ALLOW  = 5;
	localparam int SMP_B_INT_CLK_ON   = 6;
	localparam int SMP_B_INT_STOP_ON  = 7;
	localparam int SMP_B_EXT_CLK_ON   = 8;
	localparam int SMP_B_EXT_STOP_ON  = 9;
	localparam int SMP_B_OSC_HI_RANGE = 10;
	localparam int SMP_B_ADC_ASYNC    = 11;
	localparam int SMP_CTRL_W         = 12;

	// Status word field positions
	localparam int SMP_B_PARTIAL_POWER_DOWN_FLAG  = 0;
	localparam int SMP_B_PDF   = 1;
	localparam int SMP_B_ACK   = 2;
	localparam int SMP_B_STATE = 8;

	// Reset values
	localparam logic [11:0] SMP_CTRL_RST = 12'h000;
	localparam logic [3:0]  SMP_SYNC_RST = 4'hf;

	// Wake cause codes that select the vector
	localparam logic [2:0] SMP_SRC_RESET = 3'h0;
	localparam logic [2:0] SMP_SRC_TIMER = 3'h1;
	localparam logic [2:0] SMP_SRC_LV    = 3'h2;
	localparam logic [2:0] SMP_SRC_ADC   = 3'h3;
	localparam logic [2:0] SMP_SRC_IRQ   = 3'h4;
	localparam logic [2:0] SMP_SRC_KEY   = 3'h5;
	localparam logic [2:0] SMP_SRC_DEBUG = 3'h6;

	typedef enum logic [5:0] {
		SMP_RUN    = 6'h01,
		SMP_LIGHT  = 6'h02,
		SMP_MIDDLE = 6'h04,
		SMP_DEEP   = 6'h08,
		SMP_POR    = 6'h10,
		SMP_RESUME = 6'h20
	} smp_state_t;

	// Power, clock and pin controls driven to the rest of the chip
	typedef struct packed {
		logic cpu_clk_on;
		logic periph_clk_on;
		logic debug_clk_on;
		logic reg_full;
		logic ram_on;
		logic core_on;
		logic adc_on;
		logic ics_on;
		logic crystal_oscillator_on;
		logic pins_latched;
		logic pins_hiz;
		logic wake_pin_mode;
		logic wake_pull_off;
	} smp_pwr_t;

	localparam smp_pwr_t SMP_PWR_RUN = 13'h1fb0;

	// Interrupt requests from the peripherals
	typedef struct packed {
		logic timer;
		logic lv;
		logic adc;
		logic key;
	} smp_irq_t;

endpackage

/* hdl/smp_sequencer.sv */
// Purpose: stop-mode entry, wake-up and recovery sequencing
// Assumes: stop_done pulses once the stop instruction has completed
// Notes:   only mclk; this block stays powered in every stop level
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module smp_sequencer (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	// Avalon-MM slave
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// Core and peripherals
	input  wire logic              stop_done,
	input  wire smp_pkg::smp_irq_t irq_req,
	// Pins and analog
	input  wire logic              rst_pin_n,
	input  wire logic              irq_pin_n,
	input  wire logic              wake_pin_n,
	input  wire logic              supply_ok,
	// Debug link
	input  wire logic              dbg_bg_cmd,
	input  wire logic              dbg_stat_cmd,
	output logic                   dbg_stat_err,
	output logic                   dbg_enter_bg,
	output logic                   dbg_all_cmds,
	// System outputs
	output smp_pkg::smp_pwr_t      pwr,
	output logic                   illegal_op_rst,
	output logic                   sys_rst,
	output logic                   lv_rst_low_trip,
	output logic                   vec_fetch,
	output logic [2:0]             vec_src
);
	import smp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	logic [1:0]       rst_sync_reg;
	logic             rst_n;
	logic [3:0]       pin_s1_reg;
	logic [3:0]       pin_s2_reg;
	logic             rst_pin_low;
	logic             irq_pin_low;
	logic             wake_pin_low;
	logic             supply_good;

	// Release through two flops so no flop leaves reset on a ragged edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Pins are asynchronous; only the second stage is read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= SMP_SYNC_RST;
			pin_s2_reg <= SMP_SYNC_RST;
		end else begin
			pin_s1_reg <= {rst_pin_n, irq_pin_n, supply_ok, wake_pin_n};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	assign rst_pin_low  = !pin_s2_reg[3];
	assign irq_pin_low  = !pin_s2_reg[2];
	assign supply_good  = pin_s2_reg[1];
	assign wake_pin_low = !pin_s2_reg[0];

	////////////////////////////////////////////////////////////////////////////
	// Decoders

	// Level chosen by the configuration at stop time
	function automatic smp_state_t level_sel(input logic [SMP_CTRL_W-1:0] c);
		if (c[SMP_B_DEBUG_ALLOW]) begin
			level_sel = SMP_LIGHT;
		end else if (c[SMP_B_LV_ON] && c[SMP_B_LV_IN_STOP]) begin
			level_sel = SMP_LIGHT;
		end else if (!c[SMP_B_PDC]) begin
			level_sel = SMP_LIGHT;
		end else if (c[SMP_B_PARTIAL_POWER_DOWN_CTL]) begin
			level_sel = SMP_MIDDLE;
		end else begin
			level_sel = SMP_DEEP;
		end
	endfunction

	// Register select on the byte address
	function automatic logic is_reg(input logic [3:0] a, input logic [3:0] ofs);
		is_reg = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bus

	logic                  wait_reg;
	logic [31:0]           rdata_reg;
	logic [SMP_CTRL_W-1:0] ctrl_reg;
	logic [SMP_CTRL_W-1:0] cfg_reg;
	logic                  partial_power_down_flag_reg;
	logic                  pdf_reg;
	logic                  wr_take;
	logic                  ack_wr;
	smp_state_t            state_reg;
	smp_state_t            state_next;
	logic                  lv_both;

	// One wait cycle per access; the request is taken when wait is low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end
	assign wr_take = avs_write && !wait_reg;
	assign ack_wr  = wr_take && is_reg(avs_address, SMP_OFS_STATUS)
		&& avs_byteenable[0] && avs_writedata[SMP_B_ACK];

	// Read data captured as wait drops; unmapped reads give zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0;
		end else if (avs_read && wait_reg) begin
			if (is_reg(avs_address, SMP_OFS_CTRL)) begin
				rdata_reg <= {20'h0, ctrl_reg};
			end else if (is_reg(avs_address, SMP_OFS_STATUS)) begin
				rdata_reg <= {18'h0, state_reg, 6'h0, pdf_reg, partial_power_down_flag_reg};
			end else begin
				rdata_reg <= 32'h0;
			end
		end
	end

	// Control word; a power-on style restart clears it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= SMP_CTRL_RST;
		end else if (state_next == SMP_POR) begin
			ctrl_reg <= SMP_CTRL_RST;
		end else if (wr_take && is_reg(avs_address, SMP_OFS_CTRL)) begin
			if (avs_byteenable[0]) begin
				ctrl_reg[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				ctrl_reg[11:8] <= avs_writedata[11:8];
			end
		end
	end

	// Snapshot at entry so bus writes while stopped cannot alter the level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= SMP_CTRL_RST;
		end else if (state_reg == SMP_RUN && stop_done) begin
			cfg_reg <= ctrl_reg;
		end
	end
	assign lv_both = cfg_reg[SMP_B_LV_ON] && cfg_reg[SMP_B_LV_IN_STOP];

	// Recovery flags; a wake in the same cycle as the ack wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			partial_power_down_flag_reg <= 1'b0;
			pdf_reg  <= 1'b0;
		end else begin
			if (state_reg == SMP_MIDDLE && state_next == SMP_POR) begin
				partial_power_down_flag_reg <= 1'b1;
			end else if (ack_wr) begin
				partial_power_down_flag_reg <= 1'b0;
			end
			if (state_reg == SMP_DEEP && state_next == SMP_POR) begin
				pdf_reg <= 1'b1;
			end else if (ack_wr) begin
				pdf_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	logic       any_irq;
	logic [2:0] irq_src;

	// Reset pin outranks every interrupt
	always_comb begin
		any_irq = 1'b1;
		irq_src = SMP_SRC_RESET;
		if (irq_req.timer) begin
			irq_src = SMP_SRC_TIMER;
		end else if (irq_req.lv) begin
			irq_src = SMP_SRC_LV;
		end else if (irq_req.adc) begin
			irq_src = SMP_SRC_ADC;
		end else if (irq_pin_low) begin
			irq_src = SMP_SRC_IRQ;
		end else if (irq_req.key) begin
			irq_src = SMP_SRC_KEY;
		end else begin
			any_irq = 1'b0;
		end
	end

	// Level changes
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SMP_RUN: begin
				if (stop_done && ctrl_reg[SMP_B_STOP_ALLOW]) begin
					state_next = level_sel(ctrl_reg);
				end
			end
			SMP_LIGHT: begin
				if (rst_pin_low || any_irq) begin
					state_next = SMP_RESUME;
				end else if (cfg_reg[SMP_B_DEBUG_ALLOW] && dbg_bg_cmd) begin
					state_next = SMP_RESUME;
				end
			end
			SMP_MIDDLE, SMP_DEEP: begin
				if (wake_pin_low || irq_req.timer) begin
					state_next = SMP_POR;
				end
			end
			SMP_POR: begin
				if (supply_good) begin
					state_next = SMP_RESUME;
				end
			end
			SMP_RESUME: begin
				state_next = SMP_RUN;
			end
			default: begin
				state_next = SMP_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SMP_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake cause, vector and reset requests

	logic [2:0] src_reg;
	logic       bg_wake_reg;
	logic       fetch_reg;
	logic       illegal_reg;
	logic       sys_rst_reg;
	logic       low_trip_reg;

	// Cause recorded when the level is left
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_reg     <= SMP_SRC_RESET;
			bg_wake_reg <= 1'b0;
		end else begin
			bg_wake_reg <= 1'b0;
			if (state_reg == SMP_LIGHT && state_next == SMP_RESUME) begin
				if (rst_pin_low) begin
					src_reg <= SMP_SRC_RESET;
				end else if (any_irq) begin
					src_reg <= irq_src;
				end else begin
					src_reg     <= SMP_SRC_DEBUG;
					bg_wake_reg <= 1'b1;
				end
			end else if (state_next == SMP_POR) begin
				src_reg <= SMP_SRC_RESET;
			end
		end
	end

	// Vector fetched one cycle after clocks restart
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_reg <= 1'b0;
		end else begin
			fetch_reg <= (state_reg == SMP_RESUME);
		end
	end

	// Stop refused: no level, illegal-opcode reset instead
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			illegal_reg <= 1'b0;
		end else begin
			illegal_reg <= (state_reg == SMP_RUN) && stop_done
				&& !ctrl_reg[SMP_B_STOP_ALLOW];
		end
	end

	// Full reset on pin exit or held through a power-on style restart
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sys_rst_reg  <= 1'b0;
			low_trip_reg <= 1'b0;
		end else begin
			sys_rst_reg <= (state_next == SMP_POR)
				|| (state_reg == SMP_LIGHT && rst_pin_low);
			low_trip_reg <= (state_next == SMP_POR);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Debug link answers

	logic stat_err_reg;
	logic all_cmds_reg;

	// No memory access while stopped; only status with an error comes back
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_err_reg <= 1'b0;
			all_cmds_reg <= 1'b1;
		end else begin
			stat_err_reg <= dbg_stat_cmd && (state_reg != SMP_RUN);
			all_cmds_reg <= (state_next == SMP_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power, clock and pin controls

	smp_pwr_t pwr_next;
	smp_pwr_t pwr_reg;

	always_comb begin
		pwr_next = SMP_PWR_RUN;
		pwr_next.pins_latched = (partial_power_down_flag_reg && !ack_wr) || (state_reg == SMP_MIDDLE);
		case (state_next)
			SMP_LIGHT: begin
				// Registers, RAM and pins simply hold; clocks stop, regulator leaves full regulation unless kept
				pwr_next.cpu_clk_on    = 1'b0;
				pwr_next.periph_clk_on = 1'b0;
				pwr_next.debug_clk_on  = cfg_reg[SMP_B_DEBUG_ALLOW];
				pwr_next.reg_full = lv_both || cfg_reg[SMP_B_DEBUG_ALLOW];
				pwr_next.adc_on = cfg_reg[SMP_B_ADC_ASYNC] && lv_both;
				pwr_next.ics_on = cfg_reg[SMP_B_INT_CLK_ON]
					&& cfg_reg[SMP_B_INT_STOP_ON];
				pwr_next.crystal_oscillator_on = cfg_reg[SMP_B_EXT_CLK_ON] && cfg_reg[SMP_B_EXT_STOP_ON]
					&& (!cfg_reg[SMP_B_OSC_HI_RANGE] || lv_both);
			end
			SMP_MIDDLE: begin
				pwr_next = '0;
				pwr_next.ram_on        = 1'b1;
				pwr_next.pins_latched  = 1'b1;
				pwr_next.wake_pin_mode = 1'b1;
				pwr_next.wake_pull_off = 1'b1;
			end
			SMP_DEEP: begin
				pwr_next = '0;
				pwr_next.pins_hiz      = 1'b1;
				pwr_next.wake_pin_mode = 1'b1;
				pwr_next.wake_pull_off = 1'b1;
			end
			SMP_POR: begin
				// Core held in reset with clocks off until supply clears the low trip
				pwr_next.cpu_clk_on    = 1'b0;
				pwr_next.periph_clk_on = 1'b0;
				pwr_next.pins_hiz      = !partial_power_down_flag_reg && (state_reg != SMP_MIDDLE);
			end
			SMP_RUN, SMP_RESUME: begin
				pwr_next.cpu_clk_on = 1'b1;
			end
			default: begin
				pwr_next = SMP_PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_reg <= SMP_PWR_RUN;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign dbg_stat_err    = stat_err_reg;
	assign dbg_enter_bg    = bg_wake_reg;
	assign dbg_all_cmds    = all_cmds_reg;
	assign pwr             = pwr_reg;
	assign illegal_op_rst  = illegal_reg;
	assign sys_rst         = sys_rst_reg;
	assign lv_rst_low_trip = low_trip_reg;
	assign vec_fetch       = fetch_reg;
	assign vec_src         = src_reg;

endmodule // smp_sequencer

`default_nettype wire

/* testbench/smp_sequencer_chk.sv */
// Purpose: port-level checks of the stop-mode sequencer
// Assumes: one clock, reset_n active low
// Notes:   bound to every smp_sequencer instance
`timescale 1ns/1ps
`default_nettype none
module smp_sequencer_chk
	import smp_pkg::*;
(
	input wire logic              mclk,
	input wire logic              reset_n,
	input wire logic [3:0]        avs_address,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [3:0]        avs_byteenable,
	input wire logic              avs_waitrequest,
	input wire logic              stop_done,
	input wire logic              supply_ok,
	input wire logic              dbg_stat_cmd,
	input wire logic              dbg_stat_err,
	input wire logic              dbg_enter_bg,
	input wire logic              dbg_all_cmds,
	input wire smp_pkg::smp_pwr_t pwr,
	input wire logic              illegal_op_rst,
	input wire logic              sys_rst,
	input wire logic              lv_rst_low_trip,
	input wire logic              vec_fetch,
	input wire logic [2:0]        vec_src
);
	logic ack_wr;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	// Ack write as taken by the bus, the only thing that opens the latches
	assign ack_wr = avs_write && !avs_waitrequest && avs_address == SMP_OFS_STATUS
		&& avs_byteenable[0] && avs_writedata[SMP_B_ACK];
	a_stat_err_reply: assert property (dbg_stat_cmd && !dbg_all_cmds |=> dbg_stat_err)
		else $error("status command while stopped got no error");
	a_bg_vector: assert property (dbg_enter_bg |=> vec_fetch && vec_src == SMP_SRC_DEBUG && dbg_all_cmds)
		else $error("background entry without debug vector");
	a_periph_off: assert property (!pwr.cpu_clk_on |-> !pwr.periph_clk_on)
		else $error("peripheral clock runs while stopped");
	a_illegal_cause: assert property ($rose(illegal_op_rst) |-> $past(stop_done) && pwr.periph_clk_on)
		else $error("illegal opcode reset without stop or left run");
	a_clk_stop_cause: assert property ($fell(pwr.cpu_clk_on) |-> $past(stop_done))
		else $error("core clock stopped without stop");
	a_fetch_clk_on: assert property (vec_fetch |-> pwr.cpu_clk_on && pwr.periph_clk_on)
		else $error("vector fetched with clocks stopped");
	a_latch_till_ack: assert property (pwr.pins_latched && !ack_wr |=> pwr.pins_latched)
		else $error("pin latches opened without ack");
	a_latch_ram_on: assert property (pwr.pins_latched |-> pwr.ram_on && !pwr.pins_hiz)
		else $error("latched pins without RAM power");
	a_hiz_wake_mode: assert property (!pwr.ram_on |-> pwr.pins_hiz && pwr.wake_pin_mode && pwr.wake_pull_off)
		else $error("RAM off without high impedance pins and wake input mode");
	a_por_holds: assert property ((sys_rst && !supply_ok) [*3] |=> sys_rst && lv_rst_low_trip)
		else $error("reset released below low trip");
	c_latched: cover property (pwr.pins_latched);
	c_hiz: cover property (pwr.pins_hiz);
	c_bg: cover property (dbg_enter_bg);
	c_illegal: cover property (illegal_op_rst);
endmodule // smp_sequencer_chk
bind smp_sequencer smp_sequencer_chk u_chk (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .stop_done(stop_done), .supply_ok(supply_ok),
	.dbg_stat_cmd(dbg_stat_cmd), .dbg_stat_err(dbg_stat_err), .dbg_enter_bg(dbg_enter_bg),
	.dbg_all_cmds(dbg_all_cmds), .pwr(pwr), .illegal_op_rst(illegal_op_rst), .sys_rst(sys_rst),
	.lv_rst_low_trip(lv_rst_low_trip), .vec_fetch(vec_fetch), .vec_src(vec_src));
`default_nettype wire

/* testbench/smp_partner.sv */
// Purpose: core, wake pin and debug link facing the sequencer
// Assumes: requests from the bench are levels
// Notes:   each stop, background and status request's rise becomes one pulse; wake is a level
`timescale 1ns/1ps
`default_nettype none
module smp_partner (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic go_stop,
	input  wire logic go_wake,
	input  wire logic go_bg,
	input  wire logic go_stat,
	output logic      stop_done,
	output logic      wake_pin_n,
	output logic      dbg_bg_cmd,
	output logic      dbg_stat_cmd
);
	logic [2:0] q_reg;
	// Pulses on rise, so a held request is never taken twice
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q_reg <= 3'h0;
			stop_done <= 1'b0;
			dbg_bg_cmd <= 1'b0;
			dbg_stat_cmd <= 1'b0;
		end else begin
			q_reg <= {go_stop, go_bg, go_stat};
			stop_done <= go_stop & ~q_reg[2];
			dbg_bg_cmd <= go_bg & ~q_reg[1];
			dbg_stat_cmd <= go_stat & ~q_reg[0];
		end
	end
	// Pin driven high between wakes; pull-up is off in deep levels
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			wake_pin_n <= 1'b1;
		else
			wake_pin_n <= ~go_wake;
	end
endmodule // smp_partner
`default_nettype wire

/* testbench/tb_stop_mode_power_sequencer.sv */
// Purpose: self-checking bench of the stop-mode sequencer
// Assumes: byteenable held at all lanes
// Notes:   row table walks every level and wake source
`timescale 1ns/1ps
`default_nettype none
module tb_stop_mode_power_sequencer;
	import smp_pkg::*;
	typedef struct packed {
		logic [11:0] ctrl;
		logic [5:0]  st;
		logic [9:0]  pb;
		logic [2:0]  wk;
		logic [2:0]  src;
	} smp_row_t;
	// pb: periph, reg_full, debug clk, ram, adc, latched, hiz, wake mode, int clock, oscillator
	smp_row_t    rows [12] = '{'{12'h000, 6'h01, 10'h3c3, 3'h0, 3'h0}, '{12'h301, 6'h02, 10'h041, 3'h1, 3'h1},
		'{12'h007, 6'h02, 10'h140, 3'h2, 3'h2}, '{12'h807, 6'h02, 10'h160, 3'h3, 3'h3},
		'{12'hf01, 6'h02, 10'h040, 3'h4, 3'h4}, '{12'h0c1, 6'h02, 10'h042, 3'h5, 3'h5},
		'{12'h021, 6'h02, 10'h1c0, 3'h6, 3'h6}, '{12'h041, 6'h02, 10'h040, 3'h0, 3'h0},
		'{12'h019, 6'h04, 10'h054, 3'h7, 3'h0}, '{12'h009, 6'h08, 10'h00c, 3'h1, 3'h0},
		'{12'h039, 6'h02, 10'h1c0, 3'h1, 3'h1}, '{12'h71f, 6'h02, 10'h141, 3'h1, 3'h1}};
	logic        mclk, reset_n, avs_read, avs_write, avs_waitrequest, rst_pin_n, irq_pin_n;
	logic        supply_ok, stop_done, wake_pin_n, dbg_bg_cmd, dbg_stat_cmd, dbg_stat_err;
	logic        dbg_enter_bg, dbg_all_cmds, illegal_op_rst, sys_rst, lv_rst_low_trip, vec_fetch;
	logic        go_stop, go_wake, go_bg, go_stat;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [2:0]  vec_src;
	smp_irq_t    irq_req;
	smp_pwr_t    pwr;
	int          fail_count, n_compared, cyc, n_ill, n_err, n_bg;
	smp_sequencer dut_u (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_done(stop_done),
		.irq_req(irq_req), .rst_pin_n(rst_pin_n), .irq_pin_n(irq_pin_n), .wake_pin_n(wake_pin_n),
		.supply_ok(supply_ok), .dbg_bg_cmd(dbg_bg_cmd), .dbg_stat_cmd(dbg_stat_cmd),
		.dbg_stat_err(dbg_stat_err), .dbg_enter_bg(dbg_enter_bg), .dbg_all_cmds(dbg_all_cmds),
		.pwr(pwr), .illegal_op_rst(illegal_op_rst), .sys_rst(sys_rst),
		.lv_rst_low_trip(lv_rst_low_trip), .vec_fetch(vec_fetch), .vec_src(vec_src));
	smp_partner u_part (.mclk(mclk), .reset_n(reset_n), .go_stop(go_stop), .go_wake(go_wake),
		.go_bg(go_bg), .go_stat(go_stat), .stop_done(stop_done), .wake_pin_n(wake_pin_n),
		.dbg_bg_cmd(dbg_bg_cmd), .dbg_stat_cmd(dbg_stat_cmd));
	////////////////////////////////////////////////////////////////
	always #25 mclk = ~mclk;
	// Pulse tallies and the hang guard
	always @(posedge mclk) begin
		n_ill <= n_ill + int'(illegal_op_rst === 1'b1);
		n_err <= n_err + int'(dbg_stat_err === 1'b1);
		n_bg <= n_bg + int'(dbg_enter_bg === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One Avalon access; waits for waitrequest low, never a fixed count
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Levels are held until the fetch shows, or 8 cycles in middle and deep, so sync delay is harmless
	task automatic wake(input logic [2:0] k, input logic v);
		@(posedge mclk);
		case (k)
			3'h0: rst_pin_n <= !v;
			3'h1: irq_req.timer <= v;
			3'h2: irq_req.lv <= v;
			3'h3: irq_req.adc <= v;
			3'h4: irq_pin_n <= !v;
			3'h5: irq_req.key <= v;
			3'h6: go_bg <= v;
			default: go_wake <= v;
		endcase
	endtask
	task automatic await_fetch(input logic [2:0] src);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (vec_fetch !== 1'b1 && n < 60);
		chk(vec_fetch, 1'b1);
		chk(vec_src, src);
	endtask
	task automatic do_reset;
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	task automatic test_done;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{mclk, reset_n, avs_read, avs_write, go_stop, go_wake, go_bg, go_stat} = 8'h00;
		{rst_pin_n, irq_pin_n, supply_ok} = 3'h7;
		{avs_address, avs_writedata, irq_req} = '0;
		{fail_count, n_compared, cyc, n_ill, n_err, n_bg} = '0;
		do_reset();
		foreach (rows[i]) begin
			bus(1'b1, SMP_OFS_CTRL, {20'h0, rows[i].ctrl});
			@(posedge mclk);
			go_stop <= 1'b1;
			@(posedge mclk);
			go_stop <= 1'b0;
			go_stat <= 1'b1;
			@(posedge mclk);
			go_stat <= 1'b0;
			repeat (3) @(posedge mclk);
			chk({pwr.periph_clk_on, pwr.reg_full, pwr.debug_clk_on, pwr.ram_on, pwr.adc_on, pwr.pins_latched,
				pwr.pins_hiz, pwr.wake_pin_mode, pwr.ics_on, pwr.crystal_oscillator_on}, rows[i].pb);
			bus(1'b0, SMP_OFS_STATUS, 32'h0);
			chk(rd[13:8], rows[i].st);
			bus(1'b0, SMP_OFS_CTRL, 32'h0);
			chk(rd[11:0], rows[i].ctrl);
			if (rows[i].st != 6'h01) begin
				if (rows[i].st[3:2] != 2'h0) begin
					@(posedge mclk);
					supply_ok <= 1'b0;
				end
				wake(rows[i].wk, 1'b1);
				if (rows[i].st[3:2] != 2'h0) begin
					repeat (8) @(posedge mclk);
					chk({sys_rst, lv_rst_low_trip}, 2'h3);
					wake(rows[i].wk, 1'b0);
					@(posedge mclk);
					supply_ok <= 1'b1;
				end
				await_fetch(rows[i].src);
				wake(rows[i].wk, 1'b0);
				if (rows[i].st[3:2] != 2'h0) begin
					bus(1'b0, SMP_OFS_STATUS, 32'h0);
					chk(rd[1:0], rows[i].st[3:2]);
					bus(1'b0, SMP_OFS_CTRL, 32'h0);
					chk(rd[11:0], 12'h000);
					chk(pwr.pins_latched, rows[i].st[2]);
					bus(1'b1, SMP_OFS_CTRL, 32'h1);
					bus(1'b1, SMP_OFS_STATUS, 32'h4);
					bus(1'b0, SMP_OFS_STATUS, 32'h0);
					chk(rd[2:0], 3'h0);
					chk(pwr.pins_latched, 1'b0);
				end
			end
		end
		chk(n_ill, 1);
		chk(n_err, 11);
		chk(n_bg, 1);
		// Unmapped place reads zero and leaves control alone
		bus(1'b1, 4'h8, 32'hfff);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, SMP_OFS_CTRL, 32'h0);
		chk(rd[11:0], rows[11].ctrl);
		bus(1'b1, SMP_OFS_CTRL, 32'hfff);
		do_reset();
		chk(pwr, SMP_PWR_RUN);
		chk(dbg_all_cmds, 1'b1);
		bus(1'b0, SMP_OFS_CTRL, 32'h0);
		chk(rd[11:0], SMP_CTRL_RST);
		test_done();
	end
endmodule // tb_stop_mode_power_sequencer
`default_nettype wire
